// *** bench/lfs_host.sv ***
// Host controller model watching the open-drain fault pin
`default_nettype none
module lfs_host
(
   // Clock
   input wire logic mclk_i,
   // Device side
   input wire logic flag_oe_i,
   input wire logic run_i,
   input wire logic mode_req_i,
   // Host view
   output logic pin_o,
   output logic mode_o,
   output logic stop_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================
   // Pin level
   // Pull-up: the pin reads high whenever nobody drains it
   assign pin_o = flag_oe_i ? 1'b0 : 1'b1;
   // ======================================
   // Mode and stop decision
   // Mode only follows the request while the device is held off
   always_ff @(posedge mclk_i)
   begin
      if (!run_i)
      begin
         mode_o <= mode_req_i;
      end
   end
   // Software decides to stop when one-shot reporting drains the pin
   always_ff @(posedge mclk_i)
   begin
      stop_o <= mode_o && !pin_o;
   end
endmodule
`default_nettype wire

// *** bench/lfs_top_tb.sv ***
// Self-checking bench of the LED fault supervisor
`default_nettype none
module lfs_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import lfs_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} lfs_rd_t;
   typedef struct {logic l; int c;} lfs_fl_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel, pen, pwr, pready, pslverr;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic stby, mode_req, mode, clr, greq, gate, pin, oe, oe_q, fo, stop;
   logic [NCH-1:0] pwm, run;
   lfs_ana_t ana;
   int bad_count, comparisons, cyc, tc;
   int seed = 97;
   lfs_rd_t rq[$];
   lfs_fl_t fq[$];
   lfs_rd_t rd;
   lfs_fl_t fl;
   always #20 mclk = ~mclk;
   lfs_top dut (.mclk_i(mclk), .reset_i(rst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .standby_ctrl_i(stby), .fault_report_select_i(mode),
      .fault_latch_clear_i(clr), .pwm_i(pwm), .boost_gate_req_i(greq),
      .ana_i(ana), .boost_gate_o(gate), .channel_run_o(run),
      .fault_flag_i(pin), .fault_flag_o(fo), .fault_flag_oe_o(oe));
   lfs_host host (.mclk_i(mclk), .flag_oe_i(oe), .run_i(stby),
      .mode_req_i(mode_req), .pin_o(pin), .mode_o(mode), .stop_o(stop));
   // ======================================
   // Compare and report
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
      cmp(g, e);
   endtask
   task automatic chk_fl(input logic [31:0] g, input logic [31:0] e);
      cmp(g, e);
   endtask
   task automatic chk_pin(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ======================================
   // Output watcher, pops the oldest note per result
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (psel && pen && pready === 1'b1 && !pwr && rq.size() > 0)
      begin
         rd = rq.pop_front();
         chk_rd(prdata & rd.m, rd.d & rd.m);
         chk_rd({31'h0, pslverr}, {31'h0, rd.e});
      end
      if (!rst && oe !== oe_q)
      begin
         if (fq.size() == 0)
         begin
            chk_fl({31'h0, oe}, {31'h0, oe_q});
         end
         else
         begin
            fl = fq.pop_front();
            chk_fl({31'h0, oe}, {31'h0, fl.l});
            if (fl.c != 0)
            begin
               chk_fl(cyc, fl.c);
            end
         end
      end
      oe_q <= oe;
   end
   // ======================================
   // Drivers
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Holds the request until pready is sampled, then releases
   task automatic apb(input logic w, input logic [AW-1:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic e);
      int n;
      n = 0;
      if (!w)
      begin
         rq.push_back('{d, m, e});
      end
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      pen <= 1'b0;
      chk_pin(n < 20, 1'b1);
      @(posedge mclk);
   endtask
   task automatic settle(input int lim);
      int n;
      n = 0;
      while ((fq.size() > 0 || rq.size() > 0) && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
      chk_fl(fq.size(), 0);
   endtask
   // ======================================
   // Watchdog
   initial
   begin
      repeat (6000) @(posedge mclk);
      bad_count++;
      $display("Error at %0t: timeout %h %h", $time, cyc, 0);
      summarize;
   end
   // ======================================
   // Main sequence
   initial
   begin
      psel = 0; pen = 0; pwr = 0; paddr = '0; pwdata = '0; stby = 0;
      mode_req = 0; clr = 0; pwm = '0; greq = 1; ana = '0; ana.uv_ok = 1;
      ana.ss_ok = 1; oe_q = 0; cyc = 0; bad_count = 0; comparisons = 0;
      tc = 2 + (($random(seed) & 32'h7FFF) % 7);
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      stby <= 1'b1;
      tick(2);
      apb(0, REG_TMR, 32'h0000_0400, 32'h0000_FFFF, 0);
      apb(0, 8'h10, 32'h0, 32'hFFFF_FFFF, 1);
      apb(1, REG_TMR, tc, 32'h0, 0);
      apb(0, REG_TMR, tc, 32'h0000_FFFF, 0);
      apb(1, REG_CHAN, 32'hFFFF_FFFF, 32'h0, 0);
      apb(0, REG_CHAN, 32'h0, 32'h003F_3F3F, 0);
      $display("Test registers done");
      pwm <= 6'($random(seed)) | 6'h01;
      ana.open[0] <= 1'b1;
      tick(3);
      ana.open[0] <= 1'b0;
      tick(4);
      apb(0, REG_CHAN, 32'h0, 32'h003F, 0);
      ana.open[0] <= 1'b1;
      fq.push_back('{1'b1, cyc + tc + 6});
      tick(tc + 12);
      settle(10);
      apb(0, REG_CHAN, 32'h0001_0001, 32'h0001_0001, 0);
      chk_pin(run[0], 1'b0);
      ana.open[0] <= 1'b0;
      tick(10);
      chk_pin(oe, 1'b1);
      clr <= 1'b1;
      fq.push_back('{1'b0, 0});
      settle(4);
      ana.open[0] <= 1'b1;
      tick(tc + 12);
      chk_pin(oe, 1'b0);
      ana.open[0] <= 1'b0;
      tick(6);
      clr <= 1'b0;
      tick(4);
      // Stop five channels, then short the survivor
      pwm <= 6'h3F;
      ana.open <= 6'h3E;
      fq.push_back('{1'b1, 0});
      tick(tc + 12);
      ana.open <= 6'h00;
      ana.short <= 6'h01;
      tick(tc + 12);
      apb(0, REG_CHAN, 32'h003E_0100, 32'h003F_3F3F, 0);
      chk_pin(run[0], 1'b1);
      ana.short <= 6'h00;
      tick(4);
      clr <= 1'b1;
      fq.push_back('{1'b0, 0});
      settle(4);
      clr <= 1'b0;
      tick(2);
      $display("Test latched channel done");
      ana.output_short_protect <= 1'b1;
      fq.push_back('{1'b1, 0});
      tick(2);
      chk_pin(gate, 1'b0);
      tick(tc + 8);
      settle(10);
      apb(0, REG_STAT, 32'h3, 32'h3, 0);
      ana.output_short_protect <= 1'b0;
      ana.uv_ok <= 1'b0;
      fq.push_back('{1'b0, 0});
      tick(3);
      chk_pin(gate, 1'b0);
      settle(4);
      ana.uv_ok <= 1'b1;
      tick(3);
      chk_pin(gate, 1'b1);
      ana.switch_overcurrent_protect <= 1'b1;
      tick(2);
      chk_pin(gate, 1'b0);
      chk_pin(oe, 1'b0);
      ana.switch_overcurrent_protect <= 1'b0;
      tick(2);
      chk_pin(gate, 1'b1);
      ana.output_overvoltage_protect <= 1'b1;
      tick(tc + 6);
      chk_pin(gate, 1'b0);
      apb(0, REG_STAT, 32'h0, 32'h21, 0);
      ana.output_overvoltage_protect <= 1'b0;
      tick(2);
      chk_pin(gate, 1'b1);
      $display("Test converter faults done");
      stby <= 1'b0;
      mode_req <= 1'b1;
      tick(2);
      stby <= 1'b1;
      tick(2);
      chk_pin(mode, 1'b1);
      ana.open[0] <= 1'b1;
      fq.push_back('{1'b1, cyc + 6});
      tick(tc + 10);
      chk_pin(stop, 1'b1);
      chk_pin(fo, 1'b0);
      chk_pin(run[0], 1'b1);
      apb(0, REG_STAT, 32'h4, 32'h7, 0);
      ana.open[0] <= 1'b0;
      fq.push_back('{1'b0, cyc + 6});
      tick(8);
      settle(10);
      $display("Test one-shot done");
      summarize;
   end
endmodule
`default_nettype wire

// *** design/lfs_chan.sv ***
// Per-channel open and short qualification
`default_nettype none
module lfs_chan
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Qualifiers
   input wire logic standby_i,
   input wire logic ss_ok_i,
   input wire logic pwm_i,
   // Sense comparators
   input wire logic open_i,
   input wire logic short_i,
   // Faults
   output logic open_flt_o,
   output logic short_flt_o
);
   import lfs_pkg::*;

   logic [CW-1:0] op_det_r;
   logic [CW-1:0] sh_det_r;
   logic [CW-1:0] hi_rel_r;
   logic [CW-1:0] lo_rel_r;
   logic [CW-1:0] sh_rel_r;
   logic pwm_q_r;
   logic qual;
   logic op_set;
   logic sh_set;
   logic op_clr;
   logic sh_clr;

   assign qual = ss_ok_i && pwm_i;
   assign op_set = qual && open_i && (op_det_r == DET_CNT - 3'h1); // R10
   assign sh_set = qual && short_i && (sh_det_r == DET_CNT - 3'h1); // R10
   assign sh_clr = !short_i && (sh_rel_r == REL_CNT - 3'h1); // R10
   // Low-side release: over three quiet cycles, or a PWM rise after three
   assign op_clr = (pwm_i && !open_i && hi_rel_r == REL_CNT - 3'h1) // R11
      || (!pwm_i && !short_i && lo_rel_r == REL_CNT) // R12
      || (pwm_i && !pwm_q_r && lo_rel_r >= REL_CNT); // R12

   // ======================================
   // Persistence counters
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !standby_i) // R20
      begin
         op_det_r <= '0;
         sh_det_r <= '0;
      end
      else
      begin
         op_det_r <= (qual && open_i && op_det_r < DET_CNT) ?
            op_det_r + 3'h1 : (qual && open_i ? op_det_r : '0);
         sh_det_r <= (qual && short_i && sh_det_r < DET_CNT) ?
            sh_det_r + 3'h1 : (qual && short_i ? sh_det_r : '0);
      end
   end

   // ======================================
   // Release counters
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !standby_i) // R20
      begin
         hi_rel_r <= '0;
         lo_rel_r <= '0;
         sh_rel_r <= '0;
         pwm_q_r <= 1'b0;
      end
      else
      begin
         pwm_q_r <= pwm_i;
         hi_rel_r <= (open_flt_o && pwm_i && !open_i) ?
            hi_rel_r + 3'h1 : '0;
         // Saturates so a late PWM rise still releases
         lo_rel_r <= (open_flt_o && !pwm_i && !short_i) ?
            ((lo_rel_r < REL_CNT) ? lo_rel_r + 3'h1 : lo_rel_r) : '0;
         sh_rel_r <= (short_flt_o && !short_i) ? sh_rel_r + 3'h1 : '0;
      end
   end

   // ======================================
   // Fault flags, detection beats release
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !standby_i)
      begin
         open_flt_o <= 1'b0;
         short_flt_o <= 1'b0;
      end
      else
      begin
         if (op_set)
            open_flt_o <= 1'b1;
         else if (op_clr)
            open_flt_o <= 1'b0;
         if (sh_set)
            short_flt_o <= 1'b1;
         else if (sh_clr)
            short_flt_o <= 1'b0;
      end
   end

   // ======================================
   // Checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i || !standby_i);

   a_open_qual: assert property ($rose(open_flt_o) |->
      $past(qual && open_i) && $past(op_det_r) == 3'h3) // R10
      else $error("open fault set without four qualified clocks");
   a_short_qual: assert property ((qual && short_i)[*4] |=> short_flt_o)
      else $error("short not flagged after four clocks"); // R10
   a_short_rel: assert property
      ((short_flt_o && !short_i && !sh_set)[*3] |=> !short_flt_o) // R10
      else $error("short fault not released after three clocks");
   a_open_hirel: assert property
      ((open_flt_o && pwm_i && !open_i)[*3] |=> !open_flt_o) // R11
      else $error("open fault not released with PWM high");
   a_open_lorel: assert property
      ((open_flt_o && !pwm_i && !short_i)[*4] |=> !open_flt_o) // R12
      else $error("open fault not released with PWM low");
   c_open_seen: cover property ($rose(open_flt_o));
endmodule
`default_nettype wire

// *** design/lfs_pkg.sv ***
// Shared constants and types of the LED fault supervisor
`default_nettype none
package lfs_pkg;
   // ======================================
   // Sizes and timing counts
   localparam int NCH = 6;
   localparam int CW = 3;
   localparam logic [CW-1:0] DET_CNT = 3'h4;
   localparam logic [CW-1:0] REL_CNT = 3'h3;
   localparam int TW = 16;
   // Delay timer terminal count, stands for the capacitor charge time
   localparam logic [TW-1:0] TMR_TC_RST = 16'h0400;
   // ======================================
   // Register map, byte addresses
   localparam int AW = 8;
   localparam logic [AW-1:0] REG_TMR = 8'h00;
   localparam logic [AW-1:0] REG_STAT = 8'h04;
   localparam logic [AW-1:0] REG_CHAN = 8'h08;
   localparam logic [AW-1:0] REG_TCNT = 8'h0C;
   // Status fields
   localparam int ST_LATCHED = 0;
   localparam int ST_SYSSTOP = 1;
   localparam int ST_MODE = 2;
   localparam int ST_DRAIN = 3;
   localparam int ST_PIN = 4;
   localparam int ST_TIMED = 5;
   localparam int ST_ACT_LSB = 8;
   // Channel fields
   localparam int CH_OPEN_LSB = 0;
   localparam int CH_SHORT_LSB = 8;
   localparam int CH_STOP_LSB = 16;
   // ======================================
   // Comparator indications from the analog side
   typedef struct packed {
      logic [NCH-1:0] open;
      logic [NCH-1:0] short;
      logic ss_ok;
      logic uv_ok;
      logic output_short_protect;
      logic output_overvoltage_protect;
      logic switch_overcurrent_protect;
   } lfs_ana_t;
endpackage
`default_nettype wire

// *** design/lfs_top.sv ***
// LED fault supervisor with APB status and control registers
//
// Summary of operation
// R1 - Fault report select low: fault flag latches until a latch release.
// R2 - Latched mode asserts the flag only after the delay timer expires.
// R3 - One-shot mode drains the fault flag at once on detection.
// R4 - One-shot flag opens once the fault is gone and the timer elapsed.
// R5 - One-shot mode never latch-stops any protection.
// R6 - The host watches the flag in one-shot mode and stops the device; the lfs_host model only raises stop_o, standby stays on.
// R7 - The host keeps the report select fixed while running.
// R8 - Boost switches only while the boost supply is good; not a shutdown.
// R9 - Boost supply undervoltage clears every latch-stop state.
// R10 - Channel faults need four qualified clocks; shorts release after three.
// R11 - Open released with PWM high after three normal clocks.
// R12 - Open released with PWM low after over three, or on PWM rise.
// R13 - Output short stops the gate at once, system at timer expiry.
// R14 - Over-current blanks the gate cycle by cycle, flag stays open.
// R15 - Latch clear input releases every latch-stop state.
// R16 - A short on the last remaining channel is never latched.
// R17 - While latch clear is high no new latch stop occurs.
// R18 - Channel and output short faults run the timer; expiry latches.
// R19 - Over-voltage stops the gate only, no timer, resumes when gone.
// R20 - Channel counters run on the clock, reset when standby inactive.
// R21 - Timer counts to a set terminal count, restarts when no fault.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`default_nettype none
module lfs_top
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [lfs_pkg::AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Control pins
   input wire logic standby_ctrl_i,
   input wire logic fault_report_select_i,
   input wire logic fault_latch_clear_i,
   input wire logic [lfs_pkg::NCH-1:0] pwm_i,
   input wire logic boost_gate_req_i,
   // Comparators
   input wire lfs_pkg::lfs_ana_t ana_i,
   // Outputs
   output logic boost_gate_o,
   output logic [lfs_pkg::NCH-1:0] channel_run_o,
   // Open-drain fault flag
   input wire logic fault_flag_i,
   output logic fault_flag_o,
   output logic fault_flag_oe_o
);
   import lfs_pkg::*;

   function automatic logic [CW-1:0] ones(input logic [NCH-1:0] v);
      logic [CW-1:0] n;
      n = '0;
      for (int i = 0; i < NCH; i++)
         n = n + {{(CW-1){1'b0}}, v[i]};
      return n;
   endfunction

   logic [NCH-1:0] open_flt;
   logic [NCH-1:0] short_flt;
   logic [NCH-1:0] ch_stop_r;
   logic [NCH-1:0] open_live;
   logic [NCH-1:0] short_live;
   logic [NCH-1:0] short_eff;
   logic [TW-1:0] tmr_tc_r;
   logic [TW-1:0] tmr_cnt_r;
   logic [TW-1:0] os_cnt_r;
   logic [31:0] rd_nxt;
   logic sys_stop_r;
   logic fault_latched_r;
   logic os_flag_r;
   logic drain_r;
   logic scp_live;
   logic timed;
   logic tmr_exp;
   logic release_all;
   logic latch_ok;
   logic sel;
   logic wr_en;
   logic mapped;

   // ======================================
   // Channel qualifiers
   generate
      for (genvar g = 0; g < NCH; g++)
      begin : g_ch
         lfs_chan u_chan
         (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .standby_i(standby_ctrl_i),
            .ss_ok_i(ana_i.ss_ok),
            .pwm_i(pwm_i[g]),
            .open_i(ana_i.open[g]),
            .short_i(ana_i.short[g]),
            .open_flt_o(open_flt[g]),
            .short_flt_o(short_flt[g])
         );
      end
   endgenerate

   // ======================================
   // Fault gathering and delay timer
   assign sel = fault_report_select_i;
   assign open_live = open_flt & ~ch_stop_r;
   assign short_live = short_flt & ~ch_stop_r;
   // Sole survivor keeps running; the boost output sags instead
   assign short_eff = (ones(~ch_stop_r) == 3'h1) ? '0 : short_live; // R16
   assign scp_live = ana_i.output_short_protect && ana_i.uv_ok && !sys_stop_r;
   // Over-voltage deliberately absent here
   assign timed = (|open_live) || (|short_eff) || scp_live; // R18 R19
   assign tmr_exp = timed && (tmr_cnt_r == tmr_tc_r); // R18
   assign release_all = fault_latch_clear_i || !ana_i.uv_ok
      || !standby_ctrl_i; // R9 R15
   assign latch_ok = !sel && !fault_latch_clear_i; // R5 R17

   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !timed) // R21
         tmr_cnt_r <= '0;
      else if (tmr_cnt_r != tmr_tc_r)
         tmr_cnt_r <= tmr_cnt_r + 16'h0001; // R21
   end

   // ======================================
   // Latch stops, latched reporting mode
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || release_all) // R9 R15
      begin
         ch_stop_r <= '0;
         sys_stop_r <= 1'b0;
         fault_latched_r <= 1'b0;
      end
      else if (latch_ok && tmr_exp) // R2 R17 R18
      begin
         ch_stop_r <= ch_stop_r | open_live | short_eff; // R16
         sys_stop_r <= sys_stop_r || scp_live; // R13
         fault_latched_r <= 1'b1; // R1
      end
   end

   // ======================================
   // One-shot reporting mode
   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !sel || !standby_ctrl_i)
         os_flag_r <= 1'b0;
      else if (timed)
         os_flag_r <= 1'b1; // R3
      else if (os_cnt_r == tmr_tc_r)
         os_flag_r <= 1'b0; // R4
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i || !os_flag_r)
         os_cnt_r <= '0;
      else if (os_cnt_r != tmr_tc_r)
         os_cnt_r <= os_cnt_r + 16'h0001; // R4
   end

   // ======================================
   // Pin drivers
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         drain_r <= 1'b0;
      else if (sel)
         drain_r <= timed || os_flag_r; // R3 R4
      else
         drain_r <= fault_latched_r || (latch_ok && tmr_exp); // R1 R2
   end

   assign fault_flag_o = 1'b0;
   assign fault_flag_oe_o = drain_r;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         boost_gate_o <= 1'b0;
      else
         boost_gate_o <= boost_gate_req_i && standby_ctrl_i
            && ana_i.uv_ok // R8
            && !ana_i.switch_overcurrent_protect // R14
            && !ana_i.output_overvoltage_protect // R19
            && !ana_i.output_short_protect && !sys_stop_r // R13
            && (ch_stop_r != {NCH{1'b1}});
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         channel_run_o <= '0;
      else
         channel_run_o <= ~ch_stop_r
            & {NCH{standby_ctrl_i && ana_i.uv_ok && !sys_stop_r}};
   end

   // ======================================
   // APB registers
   // Read data is taken in the setup cycle, so the slave never waits
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign mapped = (paddr_i == REG_TMR) || (paddr_i == REG_STAT)
      || (paddr_i == REG_CHAN) || (paddr_i == REG_TCNT);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         tmr_tc_r <= TMR_TC_RST;
      else if (wr_en && paddr_i == REG_TMR)
         tmr_tc_r <= pwdata_i[TW-1:0];
   end

   always_comb
   begin
      rd_nxt = '0;
      unique case (paddr_i)
         REG_TMR:
            rd_nxt[TW-1:0] = tmr_tc_r;
         REG_STAT:
         begin
            rd_nxt[ST_LATCHED] = fault_latched_r;
            rd_nxt[ST_SYSSTOP] = sys_stop_r;
            rd_nxt[ST_MODE] = sel;
            rd_nxt[ST_DRAIN] = drain_r;
            rd_nxt[ST_PIN] = fault_flag_i;
            rd_nxt[ST_TIMED] = timed;
            rd_nxt[ST_ACT_LSB +: CW] = ones(~ch_stop_r);
         end
         REG_CHAN:
         begin
            rd_nxt[CH_OPEN_LSB +: NCH] = open_flt;
            rd_nxt[CH_SHORT_LSB +: NCH] = short_flt;
            rd_nxt[CH_STOP_LSB +: NCH] = ch_stop_r;
         end
         REG_TCNT:
            rd_nxt[TW-1:0] = tmr_cnt_r;
         default:
            rd_nxt = '0;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
         prdata_o <= '0;
      else if (psel_i && !penable_i)
         prdata_o <= rd_nxt;
   end

   // ======================================
   // Checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   a_latch_after_timer: assert property
      ($rose(fault_latched_r) |-> $past(tmr_exp) && !$past(sel)) // R2
      else $error("latch set without timer expiry");
   a_latch_holds: assert property
      (fault_latched_r && !release_all |=> fault_latched_r) // R1
      else $error("latched fault dropped without release");
   a_oneshot_drain: assert property
      (sel && timed |=> fault_flag_oe_o) // R3
      else $error("one-shot flag not drained on fault");
   a_oneshot_nolatch: assert property
      (sel && !fault_latched_r |=> !fault_latched_r) // R5
      else $error("latch stop taken in one-shot mode");
   a_clear_all: assert property
      (fault_latch_clear_i |=> ch_stop_r == '0 && !sys_stop_r
       && !fault_latched_r) // R15 R17
      else $error("latch clear did not release");
   a_uv_release: assert property
      (!ana_i.uv_ok |=> !boost_gate_o && ch_stop_r == '0
       && !sys_stop_r) // R8 R9
      else $error("undervoltage did not stop gate or clear latches");
   a_ocp_blank: assert property
      (ana_i.switch_overcurrent_protect |=> !boost_gate_o) // R14
      else $error("gate ran during over-current");
   a_scp_gate: assert property
      (ana_i.output_short_protect |=> !boost_gate_o) // R13
      else $error("gate ran during output short");
   a_ovp_notimer: assert property
      (ana_i.output_overvoltage_protect && !timed |=> tmr_cnt_r == '0) // R19
      else $error("over-voltage started the timer");
   a_last_ch: assert property
      (ones(~ch_stop_r) == 3'h1 |=> ones(~ch_stop_r) != 3'h0
       || $past(|open_live)) // R16
      else $error("last channel stopped by a short");
   a_apb_rd: assert property
      (psel_i && !penable_i && !pwrite_i && paddr_i == REG_TMR
       |=> prdata_o[TW-1:0] == $past(tmr_tc_r))
      else $error("timer register read back wrong");

   c_latched: cover property ($rose(fault_latched_r));
   c_oneshot: cover property ($fell(os_flag_r));
   c_clear: cover property (fault_latched_r ##1 !fault_latched_r);
   c_apb_err: cover property (pslverr_o);
endmodule
`default_nettype wire
